// File: rtl/scwd_cfg.svh
// constants for the system control and watchdog register group
// assumes inclusion by the design files and the core model by bare name
`ifndef SCWD_CFG_SVH
`define SCWD_CFG_SVH
// ---------------------------------------------------------------
// register offsets within the peripheral block
// ---------------------------------------------------------------
`define SCWD_OFS_WDOG 8'hE6
`define SCWD_OFS_PSAVE 8'hF0
`define SCWD_OFS_REL 8'hF4
`define SCWD_OFS_RCFG 8'hF6
`define SCWD_OFS_RELOC 8'hFE
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SCWD_RST_RELOC 16'h20FF
`define SCWD_RST_PSAVE 16'h0000
`define SCWD_RST_WDOG 16'hC080
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCWD_RELOC_SLAVE 14
`define SCWD_RELOC_SPACE 12
`define SCWD_PS_EN 15
`define SCWD_PS_CBF 11
`define SCWD_PS_CBD 10
`define SCWD_PS_CAF 9
`define SCWD_PS_CAD 8
`define SCWD_WD_EN 15
`define SCWD_WD_RSEL 14
`define SCWD_WD_RFLAG 13
`define SCWD_WD_NFLAG 12
// writable masks: reserved bits read zero, except relocation bit 13 from reset until a write
`define SCWD_RELOC_MASK 16'h5FFF
`define SCWD_PSAVE_MASK 16'h8F07
`define SCWD_WDOG_MASK 16'hF8FF
// ---------------------------------------------------------------
// watchdog keywords and exponents
// ---------------------------------------------------------------
`define SCWD_KEY_CLR1 16'hAAAA
`define SCWD_KEY_CLR2 16'h5555
`define SCWD_KEY_CFG1 16'h3333
`define SCWD_KEY_CFG2 16'hCCCC
`define SCWD_EXP_BIT0 10
`define SCWD_EXP_BIT1 20
`define SCWD_CNT_W 27
`endif

// File: rtl/scwd_pkg.sv
// types shared by the system control and watchdog files
// assumes scwd_cfg.svh is on the include path
package scwd_pkg;
   // key sequence tracker, gray along the usual path
   typedef enum logic [1:0] {
      scwd_idle_s = 2'b00,
      scwd_clr_s = 2'b01,
      scwd_cfg1_s = 2'b11,
      scwd_cfg2_s = 2'b10
   } scwd_key_t;
endpackage

// File: rtl/scwd_wdog_if.sv
// signals between the register group and the watchdog counter
// assumes one clock domain
`timescale 1ns/1ns
interface scwd_wdog_if;
   logic enable;
   logic [7:0] period;
   logic restart;
   logic expire;
   modport regs (output enable, output period, output restart,
      input expire);
   modport cnt (input enable, input period, input restart,
      output expire);
endinterface

// File: rtl/scwd_wdog_cnt.sv
// hidden watchdog counter with power-of-two timeout
// assumes the register group drives enable, period and restart
`timescale 1ns/1ns
`include "scwd_cfg.svh"
module scwd_wdog_cnt (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   scwd_wdog_if.cnt wd
);
   logic [`SCWD_CNT_W-1:0] count;
   logic [`SCWD_CNT_W-1:0] next_count;
   logic expired;
   logic next_expired;
   logic [`SCWD_CNT_W-1:0] limit;

   // lowest set timeout bit picks the exponent
   function automatic logic [`SCWD_CNT_W-1:0] scwd_limit(
      input logic [7:0] sel);
      logic [`SCWD_CNT_W-1:0] v;
      v = '0;
      if (sel[0]) begin
         v = `SCWD_CNT_W'(1) << `SCWD_EXP_BIT0;
      end else begin
         for (int i = 7; i >= 1; i--) begin
            if (sel[i]) begin
               v = `SCWD_CNT_W'(1) << (`SCWD_EXP_BIT1 + i - 1);
            end
         end
      end
      return v;
   endfunction

   assign limit = scwd_limit(wd.period);
   assign wd.expire = expired;

   // count cycles, restart after each timeout
   always_comb begin
      next_count = count;
      next_expired = 1'b0;
      if (wd.restart || !wd.enable) begin
         next_count = '0;
      end else if (limit != '0) begin
         if (count == limit - `SCWD_CNT_W'(1)) begin
            next_count = '0;
            next_expired = 1'b1;
         end else begin
            next_count = count + `SCWD_CNT_W'(1);
         end
      end
   end

   // register the counter state
   always_ff @(posedge clk) begin
      if (reset) begin
         count <= '0;
         expired <= 1'b0;
      end else if (ce) begin
         count <= next_count;
         expired <= next_expired;
      end
   end
endmodule // scwd_wdog_cnt

// File: rtl/scwd_regs.sv
// system control and watchdog register group
// assumes word accesses from the core on one clock
`timescale 1ns/1ns
`include "scwd_cfg.svh"
module scwd_regs #(
   parameter logic [7:0] RELEASE_CODE = 8'h5A // arbitrary value
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [15:0] pin_levels,
   input wire logic hw_irq,
   input wire logic [19:0] cpu_addr,
   input wire logic cpu_mem,
   output logic block_hit,
   output logic irq_ctrl_slave_select,
   output logic clock_div_en,
   output logic [2:0] divider_select,
   output logic clkouta_fast,
   output logic clkouta_oe,
   output logic clkoutb_fast,
   output logic clkoutb_oe,
   output logic wdog_nmi,
   output logic wdog_sys_reset
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [15:0] reloc, next_reloc;
   logic [15:0] psave, next_psave;
   logic [15:0] wdog, next_wdog;
   logic [15:0] rcfg, next_rcfg;
   logic [15:0] rdata, next_rdata;
   logic capt_pend, next_capt_pend;
   logic hit, next_hit;
   logic nmi, next_nmi;
   logic watchdog_reset_select, next_watchdog_reset_select;
   scwd_pkg::scwd_key_t key, next_key;
   logic wd_restart;
   scwd_wdog_if wdi ();

   // offset compare used by read and write decode
   function automatic logic scwd_sel(input logic [7:0] a,
      input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // -------------------------------------------------------------
   // watchdog counter
   // -------------------------------------------------------------
   assign wdi.enable = wdog[`SCWD_WD_EN];
   assign wdi.period = wdog[7:0];
   assign wdi.restart = wd_restart;

   scwd_wdog_cnt u_cnt (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .wd(wdi.cnt)
   );

   // -------------------------------------------------------------
   // register updates
   // -------------------------------------------------------------
   always_comb begin
      logic wr_wd;
      logic wd_tick;
      wr_wd = reg_wr && scwd_sel(reg_addr, `SCWD_OFS_WDOG);
      wd_tick = (reg_rd || reg_wr)
         && scwd_sel(reg_addr, `SCWD_OFS_WDOG);
      next_reloc = reloc;
      next_psave = psave;
      next_wdog = wdog;
      next_rcfg = rcfg;
      next_capt_pend = 1'b0;
      next_key = key;
      next_nmi = 1'b0;
      next_watchdog_reset_select = 1'b0;
      wd_restart = 1'b0;
      // capture pin levels on first cycle after release
      if (capt_pend) begin
         next_rcfg = pin_levels;
      end
      if (reg_wr && scwd_sel(reg_addr, `SCWD_OFS_RELOC)) begin
         next_reloc = reg_wdata & `SCWD_RELOC_MASK;
      end
      if (reg_wr && scwd_sel(reg_addr, `SCWD_OFS_PSAVE)) begin
         next_psave = reg_wdata & `SCWD_PSAVE_MASK;
      end
      // hardware interrupt wins over a same-cycle write; only a later power save write restores it
      if (hw_irq) begin
         next_psave[`SCWD_PS_EN] = 1'b0;
      end
      // any read or write of the watchdog register clears the reset flag
      if (wd_tick) begin
         next_wdog[`SCWD_WD_RFLAG] = 1'b0;
      end
      // keyword sequences on the watchdog register
      if (wr_wd) begin
         case (key)
            scwd_pkg::scwd_clr_s: begin
               next_key = scwd_pkg::scwd_idle_s;
               if (reg_wdata == `SCWD_KEY_CLR2) begin
                  wd_restart = 1'b1;
               end
            end
            scwd_pkg::scwd_cfg1_s: begin
               next_key = (reg_wdata == `SCWD_KEY_CFG2)
                  ? scwd_pkg::scwd_cfg2_s : scwd_pkg::scwd_idle_s;
            end
            scwd_pkg::scwd_cfg2_s: begin
               next_key = scwd_pkg::scwd_idle_s;
               next_wdog = reg_wdata & `SCWD_WDOG_MASK;
               next_wdog[`SCWD_WD_RFLAG] = 1'b0;
            end
            default: begin
               if (reg_wdata == `SCWD_KEY_CLR1) begin
                  next_key = scwd_pkg::scwd_clr_s;
               end else if (reg_wdata == `SCWD_KEY_CFG1) begin
                  next_key = scwd_pkg::scwd_cfg1_s;
               end else begin
                  next_key = scwd_pkg::scwd_idle_s;
               end
            end
         endcase
      end else if (reg_rd && scwd_sel(reg_addr, `SCWD_OFS_WDOG)) begin
         // a watchdog register read between clear keywords breaks the pair
         if (key == scwd_pkg::scwd_clr_s) begin
            next_key = scwd_pkg::scwd_idle_s;
         end
      end
      // timeout: flag set wins over clearing access
      if (wdi.expire) begin
         next_wdog[`SCWD_WD_RFLAG] = 1'b1;
         if (wdog[`SCWD_WD_RSEL] || wdog[`SCWD_WD_NFLAG]) begin
            next_watchdog_reset_select = 1'b1;
         end else begin
            next_nmi = 1'b1;
            next_wdog[`SCWD_WD_NFLAG] = 1'b1;
         end
      end
      // base decode; memory ignores base bits 19-16
      if (cpu_mem != next_reloc[`SCWD_RELOC_SPACE]) begin
         next_hit = 1'b0;
      end else if (cpu_mem) begin
         next_hit = cpu_addr[15:8] == next_reloc[7:0];
      end else begin
         next_hit = cpu_addr[19:8] == next_reloc[11:0];
      end
      // read data mux
      case (reg_addr)
         `SCWD_OFS_RELOC: next_rdata = reloc;
         `SCWD_OFS_RCFG: next_rdata = rcfg;
         `SCWD_OFS_REL: next_rdata = {RELEASE_CODE, 8'h00};
         `SCWD_OFS_PSAVE: next_rdata = psave;
         `SCWD_OFS_WDOG: next_rdata = wdog;
         default: next_rdata = 16'h0000;
      endcase
      if (!reg_rd) begin
         next_rdata = rdata;
      end
   end

   // -------------------------------------------------------------
   // register the state
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         reloc <= `SCWD_RST_RELOC;
         psave <= `SCWD_RST_PSAVE;
         wdog <= `SCWD_RST_WDOG;
         rcfg <= 16'h0000;
         capt_pend <= 1'b1;
         rdata <= 16'h0000;
         hit <= 1'b0;
         nmi <= 1'b0;
         watchdog_reset_select <= 1'b0;
         key <= scwd_pkg::scwd_idle_s;
      end else if (ce) begin
         reloc <= next_reloc;
         psave <= next_psave;
         wdog <= next_wdog;
         rcfg <= next_rcfg;
         capt_pend <= next_capt_pend;
         rdata <= next_rdata;
         hit <= next_hit;
         nmi <= next_nmi;
         watchdog_reset_select <= next_watchdog_reset_select;
         key <= next_key;
      end
   end

   // -------------------------------------------------------------
   // outputs from flip-flops; the two clock output enables are inverted bits
   // -------------------------------------------------------------
   assign reg_rdata = rdata;
   assign block_hit = hit;
   assign irq_ctrl_slave_select = reloc[`SCWD_RELOC_SLAVE];
   assign clock_div_en = psave[`SCWD_PS_EN];
   assign divider_select = psave[2:0];
   assign clkouta_fast = psave[`SCWD_PS_CAF];
   assign clkoutb_fast = psave[`SCWD_PS_CBF];
   assign clkouta_oe = !psave[`SCWD_PS_CAD];
   assign clkoutb_oe = !psave[`SCWD_PS_CBD];
   assign wdog_nmi = nmi;
   assign wdog_sys_reset = watchdog_reset_select;
endmodule // scwd_regs

// File: dv/scwd_core_model.sv
// core side model issuing word accesses to the register group
// assumes the bench calls its tasks hierarchically, one at a time
`timescale 1ns/1ns
`include "scwd_cfg.svh"
module scwd_core_model (
   input wire logic clk,
   input wire logic [15:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [15:0] reg_wdata
);
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   // one write strobe, data released to its inverse afterwards
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // one read strobe, data taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // count clear keyword pair
   task automatic kick();
      wr(`SCWD_OFS_WDOG, `SCWD_KEY_CLR1);
      wr(`SCWD_OFS_WDOG, `SCWD_KEY_CLR2);
   endtask
   // unlock then configure, test bit kept zero
   task automatic cfg(input logic [15:0] d);
      wr(`SCWD_OFS_WDOG, `SCWD_KEY_CFG1);
      wr(`SCWD_OFS_WDOG, `SCWD_KEY_CFG2);
      wr(`SCWD_OFS_WDOG, d & 16'hF7FF);
   endtask
endmodule // scwd_core_model

// File: dv/scwd_regs_props.sv
// port checker for the system control and watchdog registers
// assumes one clock domain, bound to the top module
`timescale 1ns/1ns
module scwd_regs_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic hw_irq,
   input wire logic irq_ctrl_slave_select,
   input wire logic clock_div_en,
   input wire logic [2:0] divider_select,
   input wire logic clkouta_fast,
   input wire logic clkouta_oe,
   input wire logic clkoutb_fast,
   input wire logic clkoutb_oe,
   input wire logic wdog_nmi,
   input wire logic wdog_sys_reset
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic ps_wr;
   assign ps_wr = ce && reg_wr && reg_addr == 8'hF0;
   property p_ps_rst; disable iff (1'b0) reset && ce |=> !clock_div_en
      && divider_select == 3'h0 && clkouta_oe && clkoutb_oe; endproperty
   a_ps_rst: assert property (p_ps_rst) else $error("psave rst");
   property p_irq; ce && hw_irq |=> !clock_div_en; endproperty
   a_irq: assert property (p_irq) else $error("irq clear");
   property p_power_save_enable; ps_wr && !hw_irq |=>
      clock_div_en == $past(reg_wdata[15]); endproperty
   a_power_save_enable: assert property (p_power_save_enable) else $error("psave enable");
   property p_div; ps_wr |=> divider_select == $past(reg_wdata[2:0]);
   endproperty
   a_div: assert property (p_div) else $error("divider");
   property p_oe; ps_wr |=> clkouta_oe != $past(reg_wdata[8])
      && clkoutb_oe != $past(reg_wdata[10]); endproperty
   a_oe: assert property (p_oe) else $error("clock oe");
   property p_fast; ps_wr |=> clkouta_fast == $past(reg_wdata[9])
      && clkoutb_fast == $past(reg_wdata[11]); endproperty
   a_fast: assert property (p_fast) else $error("clock fast");
   property p_slave; ce && reg_wr && reg_addr == 8'hFE |=>
      irq_ctrl_slave_select == $past(reg_wdata[14]); endproperty
   a_slave: assert property (p_slave) else $error("slave");
   property p_rel; ce && reg_rd && reg_addr == 8'hF4 |=>
      reg_rdata[7:0] == 8'h00; endproperty
   a_rel: assert property (p_rel) else $error("release low");
   property p_pulse; wdog_nmi || wdog_sys_reset |=>
      !wdog_nmi && !wdog_sys_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
endmodule // scwd_regs_props
bind scwd_regs scwd_regs_props i_scwd_regs_props (.clk(clk), .reset(reset),
   .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hw_irq(hw_irq),
   .irq_ctrl_slave_select(irq_ctrl_slave_select),
   .clock_div_en(clock_div_en), .divider_select(divider_select),
   .clkouta_fast(clkouta_fast), .clkouta_oe(clkouta_oe),
   .clkoutb_fast(clkoutb_fast), .clkoutb_oe(clkoutb_oe),
   .wdog_nmi(wdog_nmi), .wdog_sys_reset(wdog_sys_reset));

// File: dv/system_control_and_watchdog_regs_tb_top.sv
// self-checking bench for the system control and watchdog registers
// assumes the core model and checker files are compiled first
`timescale 1ns/1ns
module system_control_and_watchdog_regs_tb_top;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic clk, reset, ce, rd, wr, hw_irq, cpu_mem, hit, slv, power_save_enable, af, aoe;
   logic bf, boe, nmi, srst;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, pins, d;
   logic [19:0] cpu_addr;
   logic [2:0] dsel;
   int n_errors = 0;
   int samples_checked = 0;
   scwd_regs i_scwd_regs (.clk(clk), .reset(reset), .ce(ce),
      .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata), .pin_levels(pins), .hw_irq(hw_irq),
      .cpu_addr(cpu_addr), .cpu_mem(cpu_mem), .block_hit(hit),
      .irq_ctrl_slave_select(slv), .clock_div_en(power_save_enable),
      .divider_select(dsel), .clkouta_fast(af), .clkouta_oe(aoe),
      .clkoutb_fast(bf), .clkoutb_oe(boe), .wdog_nmi(nmi),
      .wdog_sys_reset(srst));
   scwd_core_model i_scwd_core_model (.clk(clk), .reg_rdata(rdata),
      .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] act, input logic [15:0] exp);
      samples_checked++;
      if (act !== exp) begin
         n_errors++;
         $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic close_out();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // count cycles to a watchdog pulse, bounded
   task automatic wait_ev(input logic want_nmi, input int lo, input int hi);
      int n;
      for (n = 1; n <= hi; n++) begin
         @(posedge clk);
         #1;
         if ((want_nmi ? nmi : srst) === 1'b1) break;
      end
      if (n > hi) begin
         chk(16'h0, 16'h1);
         close_out();
      end else begin
         chk({15'h0, n >= lo}, 16'h1);
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_vals();
      i_scwd_core_model.rd(8'hFE, d);
      chk(d, 16'h20FF);
      i_scwd_core_model.rd(8'hF0, d);
      chk(d, 16'h0000);
      i_scwd_core_model.rd(8'hE6, d);
      chk(d, 16'hC080);
      i_scwd_core_model.rd(8'hF6, d);
      chk(d, 16'hC3A5);
      i_scwd_core_model.rd(8'hF4, d);
      chk(d, 16'h5A00);
   endtask
   task automatic t_psave();
      i_scwd_core_model.wr(8'hF0, 16'hFFFF);
      i_scwd_core_model.rd(8'hF0, d);
      chk(d, 16'h8F07);
      chk({12'h0, power_save_enable, af, aoe, boe}, 16'h000C);
      for (int i = 0; i < 8; i++) begin
         i_scwd_core_model.wr(8'hF0, 16'h8000 | 16'(i));
         chk({13'h0, dsel}, 16'(i));
      end
      hw_irq = 1'b1;
      @(posedge clk);
      #1;
      hw_irq = 1'b0;
      i_scwd_core_model.rd(8'hF0, d);
      chk(d, 16'h0007);
      chk({14'h0, af, bf}, 16'h0000);
   endtask
   task automatic t_reloc();
      i_scwd_core_model.wr(8'hFE, 16'hF123);
      i_scwd_core_model.rd(8'hFE, d);
      chk(d, 16'h5123);
      chk({15'h0, slv}, 16'h1);
      cpu_mem = 1'b1;
      cpu_addr = 20'hF2345;
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, hit}, 16'h1);
      cpu_mem = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, hit}, 16'h0);
      i_scwd_core_model.wr(8'hFE, 16'h0123);
      cpu_addr = 20'h12345;
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, hit, slv}, 16'h2);
   endtask
   task automatic t_wdog();
      i_scwd_core_model.wr(8'hE6, 16'h0000);
      i_scwd_core_model.rd(8'hE6, d);
      chk(d, 16'hC080);
      i_scwd_core_model.cfg(16'h8001);
      repeat (600) @(posedge clk);
      i_scwd_core_model.kick();
      wait_ev(1'b1, 1000, 1100);
      i_scwd_core_model.rd(8'hE6, d);
      chk(d & 16'h1000, 16'h1000);
      wait_ev(1'b0, 1000, 1100);
      i_scwd_core_model.rd(8'hE6, d);
      chk(d & 16'h3000, 16'h3000);
      i_scwd_core_model.rd(8'hE6, d);
      chk(d & 16'h2000, 16'h0000);
      i_scwd_core_model.rd(8'hF6, d);
      chk(d, 16'hC3A5);
   endtask
   // ---------------------------------------------------------------
   // clock, reset and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      hw_irq = 1'b0;
      cpu_mem = 1'b0;
      cpu_addr = 20'h00000;
      pins = 16'hC3A5;
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      pins = 16'h3C5A;
      t_reset_vals();
      t_psave();
      t_reloc();
      t_wdog();
      close_out();
   end
endmodule // system_control_and_watchdog_regs_tb_top
